// file: core/fsbc_ctrl.sv
`timescale 1ns/10ps
// What this block does
// - On the amplifier port the controller sets itself up for output selection unaided.
// - Manual mode: each selection switch toggles its own output, any combination allowed.
// - Outside programming, mute tap toggles one shared mute; both mute lamps show that state.
// - Three-second mute hold in manual mode enters bank mode.
// - Mode indicator lit in bank mode, dark in manual mode.
// - Bank mode: selection switch n recalls stored bank n and applies it.
// - Three-second mute hold in bank mode returns to manual, indicator off.
// - Eight-second mute hold enters programming at the first bank.
// - While programming, mute lamp blinks groups counting the edited bank number.
// - Programming: switches edit the bank; mute tap stores it and advances.
// - Three-second mute hold while programming leaves to bank mode.
// - Mode indicator flashes briefly on every accepted press.
// - Own four banks and own mode, independent of the rack unit.
// - Rack unit may still change live outputs while we recall banks.
// - After power-up the controller starts in manual mode.
module fsbc_ctrl #(
   parameter int HOLD_SHORT_CYC = fsbc_pkg::HOLD_SHORT_CYC,
   parameter int HOLD_LONG_CYC = fsbc_pkg::HOLD_LONG_CYC,
   parameter int FLASH_CYC = fsbc_pkg::FLASH_CYC,
   parameter int BLINK_CYC = fsbc_pkg::BLINK_CYC
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [fsbc_pkg::ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [fsbc_pkg::ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire fsbc_pkg::fsbc_sw_t sw_in,
   input wire logic amps_port_in,
   input wire logic mute_state_in,
   input wire logic [fsbc_pkg::NSEL-1:0] live_sel_in,
   output logic amps_cfg_o,
   output logic mute_toggle_o,
   output logic [fsbc_pkg::NSEL-1:0] sel_toggle_o,
   output logic sel_load_o,
   output logic [fsbc_pkg::NSEL-1:0] sel_load_data_o,
   output logic mode_indicator_o,
   output logic mute_indicator_o
);
   import fsbc_pkg::*;

   localparam logic [HOLD_W-1:0] HOLD_S = HOLD_W'(HOLD_SHORT_CYC - 1);
   localparam logic [HOLD_W-1:0] HOLD_L = HOLD_W'(HOLD_LONG_CYC - 1);
   localparam logic [HOLD_W-1:0] HOLD_SAT = HOLD_W'(HOLD_LONG_CYC);
   localparam logic [FLASH_W-1:0] FLASH_LD = FLASH_W'(FLASH_CYC);
   localparam logic [BLINK_W-1:0] BLINK_END = BLINK_W'(BLINK_CYC - 1);

   function automatic logic [BANK_AW-1:0] first_set(input logic [NSEL-1:0] v);
      logic [BANK_AW-1:0] idx;
      idx = '0;
      for (int i = NSEL - 1; i >= 0; i--) begin
         if (v[i]) begin
            idx = BANK_AW'(i);
         end
      end
      return idx;
   endfunction

   // Pin synchroniser; only the second stage is read.
   logic [SYNC_W-1:0] sync1_r, sync2_r;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= {sw_in, amps_port_in, mute_state_in, live_sel_in};
         sync2_r <= sync1_r;
      end
   end

   fsbc_sw_t sw_s;
   logic amps_s, mute_s;
   logic [NSEL-1:0] live_s;
   assign {sw_s, amps_s, mute_s, live_s} = sync2_r;

   // Control state.
   fsbc_mode_t mode_r, mode_nxt;
   fsbc_sw_t sw_prev_r, sw_prev_nxt;
   logic [HOLD_W-1:0] hold_r, hold_nxt;
   logic [FLASH_W-1:0] flash_r, flash_nxt;
   logic [BLINK_W-1:0] blink_r, blink_nxt;
   logic [SLOT_W-1:0] slot_r, slot_nxt;
   logic [BANK_AW-1:0] bank_r, bank_nxt;
   logic [NSEL-1:0] edit_r, edit_nxt;
   logic recall_r, recall_nxt, edit_ld_r, edit_ld_nxt;
   logic amps_nxt, mtog_nxt, load_nxt, mode_led_nxt, mute_led_nxt;
   logic [NSEL-1:0] stog_nxt, load_data_nxt;
   logic ctrl_en_r;
   logic en, mute_rise, mute_fall, tap, hold3, hold8, accept;
   logic [NSEL-1:0] sel_press;
   logic mem_we;
   logic [BANK_AW-1:0] mem_raddr;
   logic [NSEL-1:0] mem_rdata;

   always_comb begin
      en = ctrl_en_r && amps_s;
      sel_press = en ? (sw_s.sel & ~sw_prev_r.sel) : '0;
      mute_rise = en && sw_s.mute && !sw_prev_r.mute;
      mute_fall = en && !sw_s.mute && sw_prev_r.mute;
      tap = mute_fall && (hold_r < HOLD_S + 1'b1);
      hold3 = en && sw_s.mute && (hold_r == HOLD_S);
      hold8 = en && sw_s.mute && (hold_r == HOLD_L);
      accept = (sel_press != '0) || mute_rise;

      sw_prev_nxt = sw_s;
      // The count parks one past the long threshold, so each threshold is met once per hold.
      hold_nxt = (en && sw_s.mute) ? ((hold_r == HOLD_SAT) ? hold_r : hold_r + 1'b1) : '0;
      flash_nxt = accept ? FLASH_LD : ((flash_r != '0) ? flash_r - 1'b1 : flash_r);
      mode_nxt = mode_r;
      bank_nxt = bank_r;
      edit_nxt = edit_r;
      recall_nxt = 1'b0;
      edit_ld_nxt = 1'b0;
      mtog_nxt = 1'b0;
      stog_nxt = '0;
      load_nxt = 1'b0;
      load_data_nxt = sel_load_data_o;
      mem_we = 1'b0;
      mem_raddr = first_set(sel_press);
      amps_nxt = amps_s;

      if (recall_r) begin
         load_nxt = 1'b1;
         load_data_nxt = mem_rdata;
      end
      if (edit_ld_r) begin
         edit_nxt = mem_rdata;
         load_nxt = 1'b1;
         load_data_nxt = mem_rdata;
      end

      case (mode_r)
         FSBC_MANUAL: begin
            stog_nxt = sel_press;
            if (tap) begin
               mtog_nxt = 1'b1;
            end
            if (hold3) begin
               mode_nxt = FSBC_BANK;
            end
         end
         FSBC_BANK: begin
            if (sel_press != '0) begin
               recall_nxt = 1'b1;
            end
            if (tap) begin
               mtog_nxt = 1'b1;
            end
            if (hold3) begin
               mode_nxt = FSBC_MANUAL;
            end
         end
         FSBC_PROG: begin
            if (sel_press != '0) begin
               edit_nxt = edit_r ^ sel_press;
               load_nxt = 1'b1;
               load_data_nxt = edit_nxt;
            end
            if (tap) begin
               mem_we = 1'b1;
               bank_nxt = bank_r + BANK_STEP;
               mem_raddr = bank_nxt;
               edit_ld_nxt = 1'b1;
            end
            if (hold3) begin
               mode_nxt = FSBC_BANK;
            end
         end
         default: begin
            mode_nxt = FSBC_MANUAL;
         end
      endcase
      if (hold8) begin
         mode_nxt = FSBC_PROG;
         bank_nxt = BANK_FIRST;
         mem_raddr = BANK_FIRST;
         edit_ld_nxt = 1'b1;
      end

      // Blink groups: on in even slots while slot/2 is not above the bank index.
      if (mode_r == FSBC_PROG) begin
         blink_nxt = (blink_r == BLINK_END) ? '0 : blink_r + 1'b1;
         slot_nxt = slot_r;
         if (blink_r == BLINK_END) begin
            slot_nxt = (slot_r == BLINK_SLOTS - 1'b1) ? '0 : slot_r + 1'b1;
         end
      end else begin
         blink_nxt = '0;
         slot_nxt = '0;
      end
      if (mode_nxt == FSBC_PROG) begin
         mute_led_nxt = !slot_nxt[0] && (slot_nxt[SLOT_W-1:1] <= (SLOT_W-1)'(bank_nxt));
      end else begin
         mute_led_nxt = mute_s;
      end
      mode_led_nxt = (mode_nxt == FSBC_BANK) ^ (flash_nxt != '0);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mode_r <= FSBC_MANUAL;
         sw_prev_r <= '0;
         hold_r <= '0;
         flash_r <= '0;
         blink_r <= '0;
         slot_r <= '0;
         bank_r <= BANK_FIRST;
         edit_r <= '0;
         recall_r <= 1'b0;
         edit_ld_r <= 1'b0;
         amps_cfg_o <= 1'b0;
         mute_toggle_o <= 1'b0;
         sel_toggle_o <= '0;
         sel_load_o <= 1'b0;
         sel_load_data_o <= '0;
         mode_indicator_o <= 1'b0;
         mute_indicator_o <= 1'b0;
      end else begin
         mode_r <= mode_nxt;
         sw_prev_r <= sw_prev_nxt;
         hold_r <= hold_nxt;
         flash_r <= flash_nxt;
         blink_r <= blink_nxt;
         slot_r <= slot_nxt;
         bank_r <= bank_nxt;
         edit_r <= edit_nxt;
         recall_r <= recall_nxt;
         edit_ld_r <= edit_ld_nxt;
         amps_cfg_o <= amps_nxt;
         mute_toggle_o <= mtog_nxt;
         sel_toggle_o <= stog_nxt;
         sel_load_o <= load_nxt;
         sel_load_data_o <= load_data_nxt;
         mode_indicator_o <= mode_led_nxt;
         mute_indicator_o <= mute_led_nxt;
      end
   end

   fsbc_bank_mem u_mem (
      .aclk(aclk),
      .aresetn(aresetn),
      .we(mem_we),
      .waddr(bank_r),
      .wdata(edit_r),
      .raddr(mem_raddr),
      .rdata(mem_rdata)
   );

   // AXI4-Lite slave: address and data may arrive in either order.
   logic aw_hold_r, aw_hold_nxt, w_hold_r, w_hold_nxt;
   logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
   logic [31:0] w_data_r, w_data_nxt, rdata_nxt;
   logic [3:0] w_strb_r, w_strb_nxt;
   logic bvalid_nxt, rvalid_nxt, ctrl_en_nxt;
   logic [1:0] bresp_nxt, rresp_nxt;

   assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
   assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;

   always_comb begin
      aw_hold_nxt = aw_hold_r || (s_axi_awvalid && s_axi_awready);
      aw_addr_nxt = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : aw_addr_r;
      w_hold_nxt = w_hold_r || (s_axi_wvalid && s_axi_wready);
      w_data_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : w_data_r;
      w_strb_nxt = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : w_strb_r;
      bvalid_nxt = s_axi_bvalid && !s_axi_bready;
      bresp_nxt = s_axi_bresp;
      ctrl_en_nxt = ctrl_en_r;
      if (aw_hold_r && w_hold_r && !s_axi_bvalid) begin
         aw_hold_nxt = 1'b0;
         w_hold_nxt = 1'b0;
         bvalid_nxt = 1'b1;
         bresp_nxt = RESP_SLVERR;
         if (aw_addr_r == REG_CTRL) begin
            bresp_nxt = RESP_OKAY;
            if (w_strb_r[0]) begin
               ctrl_en_nxt = w_data_r[CTRL_EN_BIT];
            end
         end else if (aw_addr_r == REG_STATUS) begin
            bresp_nxt = RESP_OKAY;
         end
      end
      rvalid_nxt = s_axi_rvalid && !s_axi_rready;
      rdata_nxt = s_axi_rdata;
      rresp_nxt = s_axi_rresp;
      if (s_axi_arvalid && s_axi_arready) begin
         rvalid_nxt = 1'b1;
         rdata_nxt = '0;
         rresp_nxt = RESP_OKAY;
         if (s_axi_araddr == REG_CTRL) begin
            rdata_nxt[CTRL_EN_BIT] = ctrl_en_r;
         end else if (s_axi_araddr == REG_STATUS) begin
            rdata_nxt[ST_MODE_LSB +: 2] = mode_r;
            rdata_nxt[ST_BANK_LSB +: BANK_AW] = bank_r;
            rdata_nxt[ST_EDIT_LSB +: NSEL] = edit_r;
            rdata_nxt[ST_LIVE_LSB +: NSEL] = live_s;
            rdata_nxt[ST_AMPS_BIT] = amps_s;
            rdata_nxt[ST_MUTE_BIT] = mute_s;
         end else begin
            rresp_nxt = RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_hold_r <= 1'b0;
         aw_addr_r <= '0;
         w_hold_r <= 1'b0;
         w_data_r <= '0;
         w_strb_r <= '0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= RESP_OKAY;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= RESP_OKAY;
         ctrl_en_r <= CTRL_EN_RST;
      end else begin
         aw_hold_r <= aw_hold_nxt;
         aw_addr_r <= aw_addr_nxt;
         w_hold_r <= w_hold_nxt;
         w_data_r <= w_data_nxt;
         w_strb_r <= w_strb_nxt;
         s_axi_bvalid <= bvalid_nxt;
         s_axi_bresp <= bresp_nxt;
         s_axi_rvalid <= rvalid_nxt;
         s_axi_rdata <= rdata_nxt;
         s_axi_rresp <= rresp_nxt;
         ctrl_en_r <= ctrl_en_nxt;
      end
   end

   sequence s_hold3;
      hold3 && !hold8;
   endsequence
   sequence s_recall_load;
      ##1 recall_r ##1 sel_load_o;
   endsequence

   a_amps_cfg_follow: assert property (@(posedge aclk) disable iff (!aresetn)
      $changed(amps_s) |=> amps_cfg_o == $past(amps_s))
      else $error("amps_cfg_o does not follow the port sense");
   a_manual_toggle: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == FSBC_MANUAL && sel_press != '0) |=> sel_toggle_o == $past(sel_press))
      else $error("manual press did not toggle its output");
   a_mute_tap_out: assert property (@(posedge aclk) disable iff (!aresetn)
      (tap && mode_r != FSBC_PROG) |=> mute_toggle_o)
      else $error("mute tap not passed on");
   a_bank_enter: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == FSBC_MANUAL) ##0 s_hold3 |=> mode_r == FSBC_BANK)
      else $error("hold did not enter bank mode");
   a_mode_lamp: assert property (@(posedge aclk) disable iff (!aresetn)
      flash_r == '0 |-> mode_indicator_o == (mode_r == FSBC_BANK))
      else $error("mode indicator wrong");
   a_bank_recall: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == FSBC_BANK && sel_press != '0 && !hold8) |-> s_recall_load)
      else $error("bank recall not applied");
   a_bank_exit: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == FSBC_BANK) ##0 s_hold3 |=> mode_r == FSBC_MANUAL)
      else $error("hold did not leave bank mode");
   a_prog_enter: assert property (@(posedge aclk) disable iff (!aresetn)
      hold8 |=> (mode_r == FSBC_PROG && bank_r == BANK_FIRST) ##1 edit_r == mem_rdata)
      else $error("long hold did not start programming");
   a_blink_gap: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == FSBC_PROG && slot_r[0]) |-> !mute_indicator_o)
      else $error("mute lamp lit in a gap slot");
   a_prog_store: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == FSBC_PROG && tap && !hold8) |-> mem_we ##1 bank_r == $past(bank_r) + BANK_STEP)
      else $error("programming tap did not store and advance");
   a_prog_exit: assert property (@(posedge aclk) disable iff (!aresetn)
      (mode_r == FSBC_PROG) ##0 s_hold3 |=> mode_r == FSBC_BANK)
      else $error("hold did not leave programming");
   a_press_flash: assert property (@(posedge aclk) disable iff (!aresetn)
      accept |=> flash_r == FLASH_LD)
      else $error("accepted press not confirmed");
   a_hold_once: assert property (@(posedge aclk) disable iff (!aresetn)
      hold8 |=> !hold8)
      else $error("long hold acted more than once");
endmodule // fsbc_ctrl

// file: core/fsbc_pkg.sv
package fsbc_pkg;
   // Number of selection footswitches and of stored banks.
   localparam int NSEL = 4;
   localparam int BANK_AW = 2;
   localparam int NBANK = 4;
   localparam logic [BANK_AW-1:0] BANK_FIRST = 2'h0;
   localparam logic [BANK_AW-1:0] BANK_STEP = 2'h1;

   // Clock rate and documented hold times.
   localparam int CLK_KHZ = 125000;
   localparam int HOLD_SHORT_MS = 3000;
   localparam int HOLD_LONG_MS = 8000;
   localparam int FLASH_MS = 100;
   localparam int BLINK_MS = 250;
   localparam int HOLD_SHORT_CYC = HOLD_SHORT_MS * CLK_KHZ;
   localparam int HOLD_LONG_CYC = HOLD_LONG_MS * CLK_KHZ;
   localparam int FLASH_CYC = FLASH_MS * CLK_KHZ;
   localparam int BLINK_CYC = BLINK_MS * CLK_KHZ;
   localparam int HOLD_W = 30;
   localparam int FLASH_W = 24;
   localparam int BLINK_W = 25;
   localparam int SLOT_W = 4;
   localparam logic [SLOT_W-1:0] BLINK_SLOTS = 4'hA;

   // Factory bank contents, bank 0 in the low nibble.
   localparam logic [NBANK*NSEL-1:0] BANK_FACTORY = 16'hF731;

   // Register map.
   localparam int ADDR_W = 4;
   localparam logic [ADDR_W-1:0] REG_CTRL = 4'h0;
   localparam logic [ADDR_W-1:0] REG_STATUS = 4'h4;
   localparam logic CTRL_EN_RST = 1'b1;
   localparam int CTRL_EN_BIT = 0;
   localparam int ST_MODE_LSB = 0;
   localparam int ST_BANK_LSB = 2;
   localparam int ST_EDIT_LSB = 4;
   localparam int ST_LIVE_LSB = 8;
   localparam int ST_AMPS_BIT = 12;
   localparam int ST_MUTE_BIT = 13;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      FSBC_MANUAL = 2'b00,
      FSBC_BANK = 2'b01,
      FSBC_PROG = 2'b10
   } fsbc_mode_t;

   // Footswitch contacts, high while pressed.
   typedef struct packed {
      logic mute;
      logic [NSEL-1:0] sel;
   } fsbc_sw_t;

   localparam int SYNC_W = $bits(fsbc_sw_t) + 2 + NSEL;
endpackage

// file: core/fsbc_bank_mem.sv
`timescale 1ns/10ps
module fsbc_bank_mem (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic we,
   input wire logic [fsbc_pkg::BANK_AW-1:0] waddr,
   input wire logic [fsbc_pkg::NSEL-1:0] wdata,
   input wire logic [fsbc_pkg::BANK_AW-1:0] raddr,
   output logic [fsbc_pkg::NSEL-1:0] rdata
);
   import fsbc_pkg::*;

   logic [NSEL-1:0] mem_r [NBANK];
   logic [NSEL-1:0] mem_nxt [NBANK];
   logic [NSEL-1:0] rdata_nxt;

   always_comb begin
      mem_nxt = mem_r;
      if (we) begin
         mem_nxt[waddr] = wdata;
      end
      rdata_nxt = mem_r[raddr];
   end

   // Reset stands in for the factory load of the non-volatile store.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NBANK; i++) begin
            mem_r[i] <= BANK_FACTORY[i*NSEL +: NSEL];
         end
         rdata <= '0;
      end else begin
         mem_r <= mem_nxt;
         rdata <= rdata_nxt;
      end
   end
endmodule // fsbc_bank_mem

// file: test/fsbc_rack_model.sv
`timescale 1ns/10ps
// Rack unit on the far side of the cable: it owns the shared mute and the live selection.
module fsbc_rack_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic mute_toggle,
   input wire logic [fsbc_pkg::NSEL-1:0] sel_toggle,
   input wire logic sel_load,
   input wire logic [fsbc_pkg::NSEL-1:0] sel_load_data,
   input wire logic panel_mute,
   input wire logic [fsbc_pkg::NSEL-1:0] panel_sel,
   output logic mute_state,
   output logic [fsbc_pkg::NSEL-1:0] live_sel
);
   import fsbc_pkg::*;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         mute_state <= 1'b0;
         live_sel <= 4'h0;
      end else begin
         mute_state <= mute_state ^ (mute_toggle | panel_mute);
         // The front panel keeps editing the live selection even over a recalled bank.
         if (sel_load) begin
            live_sel <= sel_load_data ^ panel_sel;
         end else begin
            live_sel <= live_sel ^ sel_toggle ^ panel_sel;
         end
      end
   end
endmodule // fsbc_rack_model

// file: test/testbench.sv
`timescale 1ns/10ps
module testbench;
   import fsbc_pkg::*;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [ADDR_W-1:0] awaddr = 4'h0;
   logic [ADDR_W-1:0] araddr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0;
   logic wvalid = 1'b0;
   logic bready = 1'b0;
   logic arvalid = 1'b0;
   logic rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata;
   fsbc_sw_t sw_in = 5'h0;
   logic amps = 1'b0;
   logic panel_mute = 1'b0;
   logic [3:0] panel_sel = 4'h0;
   logic mute_st, amps_cfg, mute_tog, sel_ld, mode_ind, mute_ind;
   logic [3:0] live, sel_tog, sel_ld_d;
   int miscompares = 0;
   int total_checks = 0;

   fsbc_ctrl #(.HOLD_SHORT_CYC(20), .HOLD_LONG_CYC(50), .FLASH_CYC(4), .BLINK_CYC(3)) u_dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .sw_in(sw_in), .amps_port_in(amps), .mute_state_in(mute_st), .live_sel_in(live),
      .amps_cfg_o(amps_cfg), .mute_toggle_o(mute_tog), .sel_toggle_o(sel_tog),
      .sel_load_o(sel_ld), .sel_load_data_o(sel_ld_d), .mode_indicator_o(mode_ind),
      .mute_indicator_o(mute_ind));

   fsbc_rack_model u_rack (
      .aclk(aclk), .aresetn(aresetn), .mute_toggle(mute_tog), .sel_toggle(sel_tog),
      .sel_load(sel_ld), .sel_load_data(sel_ld_d), .panel_mute(panel_mute),
      .panel_sel(panel_sel), .mute_state(mute_st), .live_sel(live));

   initial begin
      forever #4 aclk = ~aclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Handshakes are sampled at the falling edge, where they equal their value at the next rise.
   task automatic axi_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d, output logic [1:0] rs);
      logic aw_t, w_t, b_t;
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      b_t = 1'b0;
      while (!b_t) begin
         @(negedge aclk);
         aw_t = awvalid & awready;
         w_t = wvalid & wready;
         b_t = bvalid;
         rs = bresp;
         @(posedge aclk);
         if (aw_t) awvalid <= 1'b0;
         if (w_t) wvalid <= 1'b0;
      end
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic axi_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d, output logic [1:0] rs);
      logic ar_t, r_t;
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      r_t = 1'b0;
      while (!r_t) begin
         @(negedge aclk);
         ar_t = arvalid & arready;
         r_t = rvalid;
         d = rdata;
         rs = rresp;
         @(posedge aclk);
         if (ar_t) arvalid <= 1'b0;
      end
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic st(output logic [31:0] v);
      logic [1:0] r;
      axi_rd(REG_STATUS, v, r);
   endtask

   task automatic chk_mode(input string w, input logic [1:0] m);
      logic [31:0] v;
      st(v);
      chk(w, m, v[ST_MODE_LSB +: 2]);
   endtask

   // Index 0..3 are the selection switches, 4 is the mute switch.
   task automatic tap(input int i, input int hold);
      sw_in[i] <= 1'b1;
      cyc(hold);
      sw_in[i] <= 1'b0;
      cyc(12);
   endtask

   task automatic blinks(input int exp);
      int n;
      logic prev;
      n = 0;
      @(negedge aclk);
      prev = mute_ind;
      repeat (30) begin
         @(negedge aclk);
         if (mute_ind && !prev) n++;
         prev = mute_ind;
      end
      @(posedge aclk);
      chk("blink pulses", exp, n);
   endtask

   task automatic final_report();
      $display("checks %0d miscompares %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   initial begin
      cyc(20000);
      miscompares++;
      final_report();
   end

   initial begin
      logic [31:0] v;
      logic [1:0] r;
      cyc(3);
      aresetn <= 1'b1;
      cyc(1);
      axi_rd(REG_CTRL, v, r);
      chk("ctrl reset", 32'h1, v);
      chk_mode("mode after reset", 2'h0);
      chk("amps cfg idle", 1'b0, amps_cfg);
      axi_rd(4'h8, v, r);
      chk("unmapped rresp", RESP_SLVERR, r);
      chk("unmapped rdata", 32'h0, v);
      axi_wr(4'h8, 32'h1, r);
      chk("unmapped bresp", RESP_SLVERR, r);
      axi_wr(REG_STATUS, 32'hFFFF_FFFF, r);
      chk("status bresp", RESP_OKAY, r);
      amps <= 1'b1;
      cyc(8);
      chk("amps cfg", 1'b1, amps_cfg);
      tap(0, 3);
      tap(2, 3);
      chk("manual 1 3", 4'h5, live);
      tap(0, 3);
      tap(1, 3);
      tap(3, 3);
      tap(0, 3);
      chk("manual all", 4'hF, live);
      sw_in[1] <= 1'b1;
      cyc(5);
      @(negedge aclk);
      chk("press flash", 1'b1, mode_ind);
      @(posedge aclk);
      sw_in[1] <= 1'b0;
      cyc(12);
      st(v);
      chk("status live", 4'hD, v[ST_LIVE_LSB +: 4]);
      tap(4, 3);
      chk("mute tap", 1'b1, mute_st);
      chk("mute lamp", 1'b1, mute_ind);
      panel_mute <= 1'b1;
      cyc(1);
      panel_mute <= 1'b0;
      cyc(8);
      chk("rack mute lamp", 1'b0, mute_ind);
      tap(4, 30);
      chk_mode("bank entry", 2'h1);
      chk("bank lamp", 1'b1, mode_ind);
      chk("hold no tap", 1'b0, mute_st);
      for (int n = 0; n < NBANK; n++) begin
         tap(n, 3);
         chk("recall", BANK_FACTORY[4*n +: 4], live);
      end
      panel_sel <= 4'h2;
      cyc(1);
      panel_sel <= 4'h0;
      cyc(6);
      chk("rack edit in bank", 4'hD, live);
      chk_mode("own mode kept", 2'h1);
      tap(4, 60);
      st(v);
      chk("prog mode", 2'h2, v[ST_MODE_LSB +: 2]);
      chk("prog first bank", 2'h0, v[ST_BANK_LSB +: 2]);
      blinks(1);
      tap(1, 3);
      chk("prog edit live", 4'h3, live);
      tap(4, 3);
      st(v);
      chk("prog advance", 2'h1, v[ST_BANK_LSB +: 2]);
      chk("prog no mute", 1'b0, mute_st);
      blinks(2);
      tap(4, 30);
      chk_mode("prog exit", 2'h1);
      tap(0, 3);
      chk("stored bank", 4'h3, live);
      tap(4, 30);
      chk_mode("manual again", 2'h0);
      chk("manual lamp", 1'b0, mode_ind);
      tap(4, 10);
      chk("short hold tap", 1'b1, mute_st);
      chk_mode("short hold mode", 2'h0);
      axi_wr(REG_CTRL, 32'h0, r);
      tap(0, 3);
      chk("disabled press", 4'h3, live);
      axi_wr(REG_CTRL, 32'h1, r);
      amps <= 1'b0;
      cyc(6);
      tap(0, 3);
      chk("detached press", 4'h3, live);
      chk("amps cfg off", 1'b0, amps_cfg);
      amps <= 1'b1;
      cyc(6);
      tap(4, 30);
      chk_mode("bank before reset", 2'h1);
      aresetn <= 1'b0;
      cyc(3);
      aresetn <= 1'b1;
      cyc(1);
      chk_mode("mode after power", 2'h0);
      chk("lamp after power", 1'b0, mode_ind);
      final_report();
   end
endmodule // testbench
